/* verilog/psam_regs.vh */
// register map, field positions, reset values and timing figures of the absorb monitor
`ifndef PSAM_REGS_VH
`define PSAM_REGS_VH

// register indices; byte address is four times the index
`define PSAM_IDX_CTRL        12'h110
`define PSAM_IDX_ERR_THR     12'h111
`define PSAM_IDX_SLOPE_THR   12'h112
`define PSAM_IDX_END_INTVL   12'h113
`define PSAM_IDX_TIMEOUT     12'h114
`define PSAM_IDX_EVT_COUNT   12'h115
`define PSAM_IDX_PHASE_SUM   12'h116

// control register fields
`define PSAM_CTRL_EN_BIT     0
`define PSAM_CTRL_CNT_RUN    1
`define PSAM_CTRL_SUM_RUN    2
`define PSAM_CTRL_WIDTH      3

// reset values
`define PSAM_RST_CTRL        3'h0
`define PSAM_RST_ERR_THR     8'h23
`define PSAM_RST_SLOPE_THR   8'h70
`define PSAM_RST_END_INTVL   8'h20
`define PSAM_RST_TIMEOUT     8'h64
`define PSAM_RST_EVT_COUNT   8'h00
`define PSAM_RST_PHASE_SUM   24'h000000

// threshold units, phase error is in 1 ns steps
`define PSAM_ERR_UNIT_NS     15'd100
`define PSAM_SLOPE_UNIT_NS   15'd10

// timing: one interval step is 10 ms, slope is judged over 0.1 s
`define PSAM_CLK_PERIOD_NS   4
`define PSAM_STEP_TIME_NS    10000000
`define PSAM_SLOPE_TIME_NS   100000000
`define PSAM_STEP_CYCLES     (`PSAM_STEP_TIME_NS / `PSAM_CLK_PERIOD_NS)
`define PSAM_SLOPE_STEPS     (`PSAM_SLOPE_TIME_NS / `PSAM_STEP_TIME_NS)

// bus answers
`define PSAM_RESP_OKAY       2'h0
`define PSAM_RESP_SLVERR     2'h2

`endif

/* verilog/psam_div.v */
// enable divider: one-cycle pulse every DIV enabled cycles
`timescale 1ns/100ps
`default_nettype none

module psam_div #(
    parameter DIV = 10
) (
    // clock and reset
    input  wire        mclk,
    input  wire        reset,
    // enable in, pulse out
    input  wire        ce,
    output reg         tick_r
);

    reg  [31:0] cnt_r;  // counts enabled cycles

    // count enabled cycles, pulse on the last one of each period
    always @(posedge mclk) begin
        if (reset) begin
            cnt_r  <= 32'h00000000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (ce) begin
                if (cnt_r >= DIV - 1) begin
                    cnt_r  <= 32'h00000000;
                    tick_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 32'h00000001;
                end
            end
        end
    end

endmodule // psam_div

`default_nettype wire

/* verilog/psam_evcnt.v */
// saturating event counter held at zero while its run bit is low
`timescale 1ns/100ps
`default_nettype none

module psam_evcnt #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             mclk,
    input  wire             reset,
    // control and event
    input  wire             run,
    input  wire             inc,
    output reg  [WIDTH-1:0] cnt_r
);

    // clear while stopped, otherwise count up and stick at all ones
    always @(posedge mclk) begin
        if (reset || !run) begin
            cnt_r <= {WIDTH{1'b0}};
        end else if (inc && (cnt_r != {WIDTH{1'b1}})) begin
            cnt_r <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule // psam_evcnt

`default_nettype wire

/* verilog/psam_top.v */
// phase-step absorb monitor for loop channel zero, with AXI4-Lite register slave
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "psam_regs.vh"

// Operation
// - 8-bit error threshold, above it is transient
// - absorb needs magnitude and slope both exceeded; after a timeout the code checks slope only, not magnitude
// - 8-bit slope threshold, 10ns/0.1s steps, reset 0x70
// - transient ends after quiet end interval
// - timeout: slope still exceeded means no absorb
// - timeout value zero disables timeout
// - absorb count saturates at 255
// - count-run bit low clears counter
// - signed 24-bit absorbed phase sum, 1 ns
// - sum-run bit low clears phase sum
// - feature works only while enable bit high
// - count-run high counts, low holds zero
// - sum-run high measures, low holds zero
module psam_top #(
    parameter STEP_CYCLES = `PSAM_STEP_CYCLES,
    parameter SLOPE_STEPS = `PSAM_SLOPE_STEPS
) (
    // clock and reset
    input  wire        mclk,
    input  wire        reset,
    // phase error samples from the detector, signed ns
    input  wire [23:0] phase_err,
    input  wire        phase_err_valid,
    // absorb result towards the loop
    output reg         absorb_pulse_r,
    output reg  [23:0] absorb_step_r,
    output reg         transient_active_r,
    // axi4-lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // one-hot states
    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_TRANS  = 3'b010;
    localparam [2:0] ST_ABSORB = 3'b100;

    // software registers
    reg  [2:0]  ctrl_r;             // run and enable bits
    reg  [7:0]  err_thr_r;          // magnitude threshold, 100 ns units
    reg  [7:0]  slope_thr_r;        // slope threshold, 10 ns per 0.1 s
    reg  [7:0]  end_intvl_r;        // quiet time that ends a transient
    reg  [7:0]  timeout_r;          // give-up time, zero turns it off
    reg  [23:0] phase_sum_r;        // cumulative absorbed phase
    wire [7:0]  evt_count;          // saturating absorb count

    // bus bookkeeping
    reg         aw_hold_r;          // write address captured
    reg         w_hold_r;           // write data captured
    reg  [9:0]  aw_idx_r;           // captured word index
    reg  [31:0] wdata_r;            // captured write data
    reg  [3:0]  wstrb_r;            // captured byte strobes
    reg  [1:0]  rresp_nxt;          // read answer code
    reg  [31:0] rdata_nxt;          // read mux result
    wire        wr_go;              // both halves of a write present
    wire        wr_hit;             // write index is mapped
    wire [9:0]  ar_idx;             // read word index

    // detector state
    reg  [2:0]  state_r;            // one-hot state
    reg  [23:0] err_r;              // latest phase error sample
    reg  [23:0] slope_ref_r;        // sample taken at last slope check
    reg  [23:0] base_r;             // phase error before the transient
    reg  [7:0]  quiet_cnt_r;        // steps since last slope exceedance
    reg  [7:0]  to_cnt_r;           // steps since the transient began
    reg         slope_hit_r;        // slope exceeded during this transient
    reg         slope_now_r;        // last slope check exceeded
    wire        step_tick;          // 10 ms pulse
    wire        slope_tick;         // 0.1 s pulse
    wire        feat_en;            // feature enable
    wire        cnt_run;            // count-run bit
    wire        sum_run;            // sum-run bit

    // magnitude and slope arithmetic
    wire [24:0] err_ext;            // sign-extended error
    wire [24:0] err_abs;            // magnitude of error
    wire [24:0] delta;              // change over one slope window
    wire [24:0] delta_abs;          // magnitude of that change
    wire [14:0] err_lim;            // threshold in ns
    wire [14:0] slope_lim;          // slope threshold in ns per window
    wire        err_over;           // magnitude exceeded
    wire        slope_over;         // slope exceeded
    wire [24:0] step_full;          // absorbed step before trimming
    wire        absorb;             // absorb this cycle

    assign feat_en   = ctrl_r[`PSAM_CTRL_EN_BIT];
    assign cnt_run   = ctrl_r[`PSAM_CTRL_CNT_RUN];
    assign sum_run   = ctrl_r[`PSAM_CTRL_SUM_RUN];

    assign err_ext   = {err_r[23], err_r};
    assign err_abs   = err_r[23] ? (25'd0 - err_ext) : err_ext;
    assign delta     = err_ext - {slope_ref_r[23], slope_ref_r};
    assign delta_abs = delta[24] ? (25'd0 - delta) : delta;
    assign err_lim   = err_thr_r * `PSAM_ERR_UNIT_NS;
    assign slope_lim = slope_thr_r * `PSAM_SLOPE_UNIT_NS;
    assign err_over  = err_abs > {10'd0, err_lim};
    assign slope_over = delta_abs > {10'd0, slope_lim};
    assign step_full = err_ext - {base_r[23], base_r};
    assign absorb    = (state_r == ST_ABSORB);

    // 10 ms step timer, then 0.1 s slope window from it
    psam_div #(
        .DIV (STEP_CYCLES)
    ) u_step_div (
        .mclk   (mclk),
        .reset  (reset),
        .ce     (1'b1),
        .tick_r (step_tick)
    );

    psam_div #(
        .DIV (SLOPE_STEPS)
    ) u_slope_div (
        .mclk   (mclk),
        .reset  (reset),
        .ce     (step_tick),
        .tick_r (slope_tick)
    );

    // absorb counter: run bit low holds it cleared
    psam_evcnt #(
        .WIDTH (8)
    ) u_evcnt (
        .mclk  (mclk),
        .reset (reset),
        .run   (cnt_run),
        .inc   (absorb),
        .cnt_r (evt_count)
    );

    // sample capture and slope reference, once per window
    always @(posedge mclk) begin
        if (reset) begin
            err_r       <= 24'h000000;
            slope_ref_r <= 24'h000000;
            slope_now_r <= 1'b0;
        end else begin
            if (phase_err_valid) begin
                err_r <= phase_err;
            end
            if (slope_tick) begin
                slope_ref_r <= err_r;
                slope_now_r <= slope_over;
            end
        end
    end

    // transient detection and absorb decision
    // a disabled feature drops any transient in flight, so stale counts never absorb
    always @(posedge mclk) begin
        if (reset || !feat_en) begin
            state_r     <= ST_IDLE;
            base_r      <= 24'h000000;
            quiet_cnt_r <= 8'h00;
            to_cnt_r    <= 8'h00;
            slope_hit_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // error beyond threshold starts a transient
                    if (err_over) begin
                        state_r     <= ST_TRANS;
                        base_r      <= slope_ref_r;
                        quiet_cnt_r <= 8'h00;
                        to_cnt_r    <= 8'h00;
                        slope_hit_r <= 1'b0;
                    end
                end
                ST_TRANS: begin
                    if (slope_tick && slope_over) begin
                        // fresh slope exceedance restarts the quiet time
                        slope_hit_r <= 1'b1;
                        quiet_cnt_r <= 8'h00;
                    end else if (step_tick) begin
                        if (quiet_cnt_r >= end_intvl_r) begin
                            // transient over; slope must have been seen
                            state_r <= (slope_hit_r && err_over) ? ST_ABSORB
                                                                 : ST_IDLE;
                        end else if ((timeout_r != 8'h00) &&
                                     (to_cnt_r >= timeout_r)) begin
                            // timed out: give up while slope still steep
                            state_r <= (slope_hit_r && !slope_now_r) ? ST_ABSORB
                                                                     : ST_IDLE;
                        end
                        quiet_cnt_r <= quiet_cnt_r + 8'h01;
                        if (to_cnt_r != 8'hFF) begin
                            to_cnt_r <= to_cnt_r + 8'h01;
                        end
                    end
                end
                ST_ABSORB: begin
                    // one cycle; count and sum take it together
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // cumulative phase: wraps as two's complement, range is software's concern
    always @(posedge mclk) begin
        if (reset || !sum_run) begin
            phase_sum_r <= `PSAM_RST_PHASE_SUM;
        end else if (absorb) begin
            phase_sum_r <= phase_sum_r + step_full[23:0];
        end
    end

    // absorb result outputs for the loop
    always @(posedge mclk) begin
        if (reset) begin
            absorb_pulse_r     <= 1'b0;
            absorb_step_r      <= 24'h000000;
            transient_active_r <= 1'b0;
        end else begin
            absorb_pulse_r     <= absorb;
            transient_active_r <= (state_r == ST_TRANS);
            if (absorb) begin
                absorb_step_r <= step_full[23:0];
            end
        end
    end

    // write path: address and data taken in either order
    assign wr_go  = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign wr_hit = ({2'h0, aw_idx_r} >= `PSAM_IDX_CTRL) &&
                    ({2'h0, aw_idx_r} <= `PSAM_IDX_PHASE_SUM);

    always @(posedge mclk) begin
        if (reset) begin
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            aw_idx_r      <= 10'h000;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PSAM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r     <= 1'b1;
                aw_idx_r      <= s_axi_awaddr[11:2];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r     <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                // unmapped words answer with an error, read-only ones ignore data
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `PSAM_RESP_OKAY : `PSAM_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // register writes, low byte lane only
    always @(posedge mclk) begin
        if (reset) begin
            ctrl_r      <= `PSAM_RST_CTRL;
            err_thr_r   <= `PSAM_RST_ERR_THR;
            slope_thr_r <= `PSAM_RST_SLOPE_THR;
            end_intvl_r <= `PSAM_RST_END_INTVL;
            timeout_r   <= `PSAM_RST_TIMEOUT;
        end else if (wr_go && wstrb_r[0]) begin
            case ({2'h0, aw_idx_r})
                `PSAM_IDX_CTRL:      ctrl_r      <= wdata_r[`PSAM_CTRL_WIDTH-1:0];
                `PSAM_IDX_ERR_THR:   err_thr_r   <= wdata_r[7:0];
                `PSAM_IDX_SLOPE_THR: slope_thr_r <= wdata_r[7:0];
                `PSAM_IDX_END_INTVL: end_intvl_r <= wdata_r[7:0];
                `PSAM_IDX_TIMEOUT:   timeout_r   <= wdata_r[7:0];
                default: begin
                    // read-only and unmapped words keep their value
                    ctrl_r <= ctrl_r;
                end
            endcase
        end
    end

    // read mux; unused upper bits read zero
    assign ar_idx = s_axi_araddr[11:2];

    always @* begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = `PSAM_RESP_OKAY;
        case ({2'h0, ar_idx})
            `PSAM_IDX_CTRL:      rdata_nxt = {29'd0, ctrl_r};
            `PSAM_IDX_ERR_THR:   rdata_nxt = {24'd0, err_thr_r};
            `PSAM_IDX_SLOPE_THR: rdata_nxt = {24'd0, slope_thr_r};
            `PSAM_IDX_END_INTVL: rdata_nxt = {24'd0, end_intvl_r};
            `PSAM_IDX_TIMEOUT:   rdata_nxt = {24'd0, timeout_r};
            `PSAM_IDX_EVT_COUNT: rdata_nxt = {24'd0, evt_count};
            `PSAM_IDX_PHASE_SUM: rdata_nxt = {8'd0, phase_sum_r};
            default: begin
                rresp_nxt = `PSAM_RESP_SLVERR;
            end
        endcase
    end

    // read path: answer one cycle after the address is taken
    always @(posedge mclk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `PSAM_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdata_nxt;
                s_axi_rresp   <= rresp_nxt;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // psam_top

`default_nettype wire

/* verif/psam_props.sv */
// port assertions of the absorb monitor, bound to its top
`timescale 1ns/100ps
`default_nettype none
`include "psam_regs.vh"
module psam_props (
    // clock and reset
    input wire logic        mclk,
    input wire logic        reset,
    // absorb result
    input wire logic        absorb_pulse_r,
    input wire logic [23:0] absorb_step_r,
    input wire logic        transient_active_r,
    // write handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    // read handshakes
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // both write halves taken at once
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // response low one cycle, then high
    sequence s_b_late;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    a_write_answer: assert property (s_wr_take |=> s_b_late)
        else $error("write response timing wrong");
    a_ready_hold: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready high during response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data timing wrong");
    a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not released");
    a_err_rdata: assert property (s_axi_rvalid && s_axi_rresp == `PSAM_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read with nonzero data");
    a_rd_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
        else $error("read data upper byte set");
    a_pulse_single: assert property (absorb_pulse_r |=> !absorb_pulse_r)
        else $error("absorb pulse too long");
    a_pulse_cause: assert property ($rose(absorb_pulse_r) |-> $past(transient_active_r))
        else $error("absorb without transient");
    a_step_holds: assert property (!absorb_pulse_r |-> $stable(absorb_step_r))
        else $error("step changed without pulse");
endmodule // psam_props
bind psam_top psam_props psam_props_i (
    .mclk(mclk), .reset(reset), .absorb_pulse_r(absorb_pulse_r),
    .absorb_step_r(absorb_step_r), .transient_active_r(transient_active_r),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench of the absorb monitor
`timescale 1ns/100ps
`default_nettype none
`include "psam_regs.vh"
module tb_top;
    localparam SC = 8; // short step tick keeps the run small
    localparam SS = 3; // step ticks per slope window
    localparam [11:0] A_CTL = `PSAM_IDX_CTRL << 2;
    localparam [11:0] A_THR = `PSAM_IDX_ERR_THR << 2;
    localparam [11:0] A_SLP = `PSAM_IDX_SLOPE_THR << 2;
    localparam [11:0] A_END = `PSAM_IDX_END_INTVL << 2;
    localparam [11:0] A_TMO = `PSAM_IDX_TIMEOUT << 2;
    localparam [11:0] A_CNT = `PSAM_IDX_EVT_COUNT << 2;
    localparam [11:0] A_SUM = `PSAM_IDX_PHASE_SUM << 2;
    // bench-driven inputs
    logic        mclk, reset, perr_v, awvalid, wvalid, bready, arvalid, rready;
    logic [23:0] perr;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    // design outputs
    wire         pulse, trans, awready, wready, bvalid, arready, rvalid;
    wire  [23:0] step;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    // expected count and sum
    integer      n_mismatch, checks, npulse, p0;
    logic [7:0]  xcnt;
    logic [23:0] xsum;
    psam_top #(.STEP_CYCLES(SC), .SLOPE_STEPS(SS)) psam_top_i (
        .mclk(mclk), .reset(reset), .phase_err(perr), .phase_err_valid(perr_v),
        .absorb_pulse_r(pulse), .absorb_step_r(step), .transient_active_r(trans),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    // free-running 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // pulse tally
    always @(posedge mclk) begin
        if (pulse === 1'b1) npulse <= npulse + 1;
    end
    task final_report;
        begin
            if (n_mismatch == 0 && checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("Error %s expected %h got %h", nm, e, g);
            end
        end
    endtask
    // a bounded wait ran out
    task tmo;
        begin
            n_mismatch = n_mismatch + 1;
            $display("Error wait expected done got timeout");
            final_report;
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge mclk);
    endtask
    // one write, address and data offered together
    task wr(input [11:0] a, input [31:0] d, input [1:0] er);
        integer n;
        begin
            n = 0;
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge mclk);
                n = n + 1;
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid && n < 40);
            if (!bvalid) tmo;
            chk("bresp", {30'h0, er}, {30'h0, bresp});
            bready <= 1'b0;
            @(posedge mclk);
        end
    endtask
    // one read, answer taken at the rvalid edge
    task rd(input [11:0] a, input [31:0] e, input [1:0] er);
        integer n;
        begin
            n = 0;
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge mclk);
                n = n + 1;
                if (arready) arvalid <= 1'b0;
            end while (!rvalid && n < 40);
            if (!rvalid) tmo;
            chk("rdata", e, rdata);
            chk("rresp", {30'h0, er}, {30'h0, rresp});
            rready <= 1'b0;
            @(posedge mclk);
        end
    endtask
    // settle at zero, step to lv, await the pulse
    task absorb(input [23:0] lv);
        integer n;
        begin
            cyc(SC * SS * 3);
            perr <= lv;
            n = 0;
            do begin
                @(posedge mclk);
                n = n + 1;
            end while (pulse !== 1'b1 && n < 800);
            if (pulse !== 1'b1) tmo;
            chk("step", {8'h00, lv}, {8'h00, step});
            xsum = xsum + lv;
            if (xcnt != 8'hFF) xcnt = xcnt + 8'h01;
            perr <= 24'h0;
        end
    endtask
    task regs_reset;
        begin
            rd(A_CTL, 32'h0, 2'h0);
            rd(A_THR, 32'h23, 2'h0);
            rd(A_SLP, 32'h70, 2'h0);
            rd(A_END, 32'h20, 2'h0);
            rd(A_TMO, 32'h64, 2'h0);
            rd(A_CNT, 32'h0, 2'h0);
            rd(A_SUM, 32'h0, 2'h0);
        end
    endtask
    // field width, read-only count, unmapped words
    task regs_access;
        begin
            wr(A_THR, 32'h1AB, 2'h0);
            rd(A_THR, 32'hAB, 2'h0);
            wr(A_CNT, 32'h55, 2'h0);
            rd(A_CNT, 32'h0, 2'h0);
            wr(12'h7FC, 32'h1, 2'h2);
            rd(12'h800, 32'h0, 2'h2);
            wr(A_THR, 32'h1, 2'h0);
            wr(A_SLP, 32'h1, 2'h0);
            wr(A_END, 32'h3, 2'h0);
            wr(A_TMO, 32'h0, 2'h0);
            wr(A_CTL, 32'h7, 2'h0);
        end
    endtask
    // positive then negative step, signed sum
    task two_steps;
        begin
            absorb(24'h1F4);
            absorb(24'hFFFCE0);
            rd(A_CNT, {24'h0, xcnt}, 2'h0);
            rd(A_SUM, {8'h00, xsum}, 2'h0);
        end
    endtask
    // ramp steep at timeout: no absorb, plain step absorbed
    task ramp;
        integer i;
        begin
            wr(A_END, 32'hFF, 2'h0);
            wr(A_TMO, 32'h8, 2'h0);
            p0 = npulse;
            for (i = 0; i < 40; i = i + 1) begin
                perr <= perr + 24'h64;
                cyc(SC);
            end
            chk("pulses", p0, npulse);
            wr(A_CTL, 32'h6, 2'h0);
            perr <= 24'h0;
            wr(A_CTL, 32'h7, 2'h0);
            absorb(24'h12C);
            wr(A_TMO, 32'h0, 2'h0);
            wr(A_END, 32'h3, 2'h0);
        end
    endtask
    // error at threshold is jitter, one ns more is not
    task thr_edge;
        begin
            wr(A_THR, 32'h5, 2'h0);
            p0 = npulse;
            perr <= 24'h1F4;
            cyc(SC * SS * 3);
            chk("trans", 32'h0, {31'h0, trans});
            chk("pulses", p0, npulse);
            perr <= 24'h0;
            absorb(24'h1F5);
            wr(A_THR, 32'h1, 2'h0);
        end
    endtask
    // enable low: a large step is ignored
    task disabled;
        begin
            wr(A_CTL, 32'h6, 2'h0);
            p0 = npulse;
            perr <= 24'h1F4;
            cyc(SC * SS * 6);
            chk("pulses", p0, npulse);
            chk("trans", 32'h0, {31'h0, trans});
            perr <= 24'h0;
            wr(A_CTL, 32'h7, 2'h0);
        end
    endtask
    // absorb past 255, the count must stop
    task saturate;
        integer i;
        begin
            for (i = 0; i < 254; i = i + 1) begin
                absorb(24'h1F4);
            end
            rd(A_CNT, 32'hFF, 2'h0);
            rd(A_SUM, {8'h00, xsum}, 2'h0);
        end
    endtask
    // run bits low clear and hold count and sum
    task clear_runs;
        begin
            wr(A_CTL, 32'h1, 2'h0);
            rd(A_CNT, 32'h0, 2'h0);
            rd(A_SUM, 32'h0, 2'h0);
            absorb(24'h1F4);
            rd(A_CNT, 32'h0, 2'h0);
            rd(A_SUM, 32'h0, 2'h0);
        end
    endtask
    // main sequence
    initial begin
        reset = 1'b1;
        perr = 24'h0;
        perr_v = 1'b1;
        awaddr = 12'h0;
        araddr = 12'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        n_mismatch = 0;
        checks = 0;
        npulse = 0;
        xcnt = 8'h00;
        xsum = 24'h0;
        cyc(4);
        reset <= 1'b0;
        regs_reset;
        regs_access;
        two_steps;
        ramp;
        thr_edge;
        disabled;
        saturate;
        clear_runs;
        final_report;
    end
endmodule // tb_top
`default_nettype wire
